// File: design/adpp_pkg.sv
// Purpose: Shared constants and types of the actuator digital position port.
// Assumes: 20 MHz system clock; classic Wishbone register access.
// Notes: Status pins and codes are handled active high inside, inverted at pins; control pins stay active low until decode; motor pins are not inverted.
package adpp_pkg;
    // Clock and time base
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    // Default accept time of a command line, in ms
    localparam logic [7:0] DEB_MS_DEF = 8'h05;
    // Least low time the controller must give, in ms (far side)
    localparam int HOLD_MS_MIN = 30;
    // Position ranges
    localparam int NPOS_BCD = 96;
    localparam logic [6:0] BCD_MAX = 7'h60;
    localparam logic [6:0] PAR_MAX = 7'h08;
    localparam logic [6:0] PAR_OFFSET = 7'h01;
    localparam logic [6:0] POS_FIRST = 7'h01;
    localparam logic [6:0] POS_STEP = 7'h01;
    localparam logic [6:0] BCD_TENS = 7'h0A;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
    localparam logic [6:0] DEF_OFS = 7'h01;
    // Input line indices inside the synchroniser vector
    localparam int NLINES = 11;
    localparam int LN_CMD0 = 8;
    localparam int NCMD = 3;
    // Command event indices
    localparam int EV_STEP = 0;
    localparam int EV_HOME = 1;
    localparam int EV_LATCH = 2;
    // Register byte offsets
    localparam logic [3:0] ADR_CTRL = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h4;
    localparam logic [3:0] ADR_MASK = 4'h8;
    localparam logic [3:0] ADR_POS = 4'hC;
    // Status and mask bits
    localparam int ST_DONE = 0;
    localparam int ST_ERR = 1;
    localparam int ST_CMD = 2;
    localparam int ST_W = 3;
    // Move sequencer
    typedef enum logic [1:0] {
        ADPP_IDLE = 2'b00,
        ADPP_ARM = 2'b01,
        ADPP_RUN = 2'b10
    } adpp_state_t;
endpackage

// File: design/adpp_port.sv
// Purpose: Parallel digital control port of a multiposition valve actuator.
// Assumes: Motor mechanics sit outside on clk_i and answer start with busy.
// Notes: Decode mode is fixed by the PARALLEL parameter, BCD by default.
// How it works
// R01: Every control input counts as asserted when low, idle when high.
// R02: Controller holds an asserted input low at least thirty ms.
// R03: Position, run, direction and error outputs are active low.
// R04: Stuck valve stop reports position code zero, all lines high.
// R05: Two-position modes work from the step line alone.
// R06: Multiposition mode needs the controller to use step and home.
// R07: Decode mode is fixed at build time, BCD by default.
// R08: BCD mode decodes eight weighted lines into up to 96 positions.
// R09: Parallel mode accepts one asserted line only, others invalid.
// R10: Parallel lines map in weight order to positions one to eight.
// R11: Parallel mode forces the position offset to one.
// R12: Parallel mode clamps a position count above eight to eight.
// R13: Latch falling and held low samples data and moves there.
// R14: Position outputs change only after motion ends, to code zero on a stuck stop.
// R15: Step falling and held low advances exactly one position.
// R16: Home falling and held low moves to the first position.
// R17: Inputs are synchronised and accepted only after a stable ms count; data lines need only two agreeing stages.
// R18: Invalid pattern or code ignores the move and raises error.
module adpp_port
    import adpp_pkg::*;
#(
    parameter bit PARALLEL = 1'b0, // [R07]
    parameter int unsigned MS_CYCLES = CLK_HZ / MS_PER_S,
    parameter int unsigned DEF_NPOS = 10
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // Control pins, active low
    input wire logic step_n_i,
    input wire logic home_n_i,
    input wire logic latch_n_i,
    input wire logic [7:0] pos_n_i,
    // Status pins, active low
    output logic [7:0] pos_n_o,
    output logic run_n_o,
    output logic dir_n_o,
    output logic err_n_o,
    // Motor mechanics
    output logic mot_start_o,
    output logic [6:0] mot_target_o,
    output logic mot_cw_o,
    input wire logic mot_busy_i,
    input wire logic mot_stuck_i
);
    import adpp_pkg::*;

    if (MS_CYCLES < 1 || MS_CYCLES > 65535 || DEF_NPOS < 1 || DEF_NPOS > NPOS_BCD) begin : g_bad
        $error("adpp_port: parameter out of range");
    end

    localparam logic [6:0] RST_NPOS = (PARALLEL && DEF_NPOS > 8) ? PAR_MAX : 7'(DEF_NPOS);
    localparam logic [15:0] DIV_LAST = 16'(MS_CYCLES - 1);

    typedef struct packed {
        logic [NLINES-1:0] s1;
        logic [NLINES-1:0] s2;
        logic [NLINES-1:0] s3;
        logic [7:0] data;
        logic [15:0] div;
        logic tick;
        logic [NCMD-1:0][7:0] cnt;
        logic [NCMD-1:0] fired;
        adpp_state_t st;
        logic [6:0] cur;
        logic [6:0] tgt;
        logic [7:0] code;
        logic err;
        logic cw;
        logic start;
        logic [6:0] npos;
        logic [6:0] ofs;
        logic [7:0] deb;
        logic [ST_W-1:0] stat;
        logic [ST_W-1:0] mask;
        logic ack;
        logic [31:0] rdat;
    } adpp_regs_t;

    // Idle lines high and fired set; the high stages clear fired in the first cycle, so a line low at reset still fires
    localparam adpp_regs_t RST = '{
        s1: '1, s2: '1, s3: '1, data: 8'hFF, div: 16'h0000, tick: 1'b0,
        cnt: '0, fired: '1, st: ADPP_IDLE, cur: POS_FIRST, tgt: POS_FIRST,
        code: 8'h00, err: 1'b0, cw: 1'b0, start: 1'b0, npos: RST_NPOS,
        ofs: DEF_OFS, deb: DEB_MS_DEF, stat: '0, mask: '0, ack: 1'b0,
        rdat: 32'h0000_0000
    };

    // Weighted lines to position number; top bit marks a valid pattern
    function automatic logic [7:0] adpp_decode(input logic [7:0] c, input logic par);
        logic [7:0] r;
        r = 8'h00;
        if (par) begin
            for (int k = 0; k < 8; k++) begin
                if (c == (8'h01 << k)) begin
                    r = {1'b1, 7'(k + 1)}; // [R09] [R10]
                end
            end
        end else if (c[3:0] <= BCD_DIGIT_MAX && c[7:4] <= BCD_DIGIT_MAX) begin
            r = {1'b1, 7'({3'h0, c[7:4]} * BCD_TENS + {3'h0, c[3:0]})}; // [R08]
        end
        return r;
    endfunction

    // Position number back to the same line format as the input
    function automatic logic [7:0] adpp_encode(input logic [6:0] v, input logic par);
        if (par) begin
            return 8'h01 << (v - POS_FIRST);
        end
        return {4'(v / BCD_TENS), 4'(v % BCD_TENS)};
    endfunction

    function automatic logic [6:0] adpp_clamp(input logic [6:0] v, input logic [6:0] hi);
        if (v < POS_FIRST) begin
            return POS_FIRST;
        end
        return (v > hi) ? hi : v;
    endfunction

    adpp_regs_t q;
    adpp_regs_t n;
    logic [NCMD-1:0] ev;
    logic [7:0] dec;
    logic [6:0] dec_tgt;
    logic dec_ok;
    logic [6:0] step_tgt;
    logic [ST_W-1:0] st_set;
    logic hit;
    logic wr;

    // Latch decode and step target, offset removed to get the physical index
    always_comb begin
        dec = adpp_decode(~q.data, PARALLEL); // [R01]
        dec_tgt = 7'(dec[6:0] - q.ofs + POS_FIRST);
        dec_ok = dec[7] && dec[6:0] != 7'h00 && dec[6:0] >= q.ofs && dec_tgt <= q.npos;
        step_tgt = (q.cur >= q.npos) ? POS_FIRST : 7'(q.cur + POS_STEP); // [R15]
    end

    always_comb begin
        n = q;
        ev = '0;
        st_set = '0;
        hit = wb_cyc_i && wb_stb_i;
        wr = hit && q.ack && wb_we_i;
        // Three-stage synchroniser; s1 feeds only s2
        n.s1 = {latch_n_i, home_n_i, step_n_i, pos_n_i};
        n.s2 = q.s1;
        n.s3 = q.s2;
        // Data bits follow only where the last two stages agree
        n.data = (q.s3[7:0] & ~(q.s2[7:0] ^ q.s3[7:0])) | (q.data & (q.s2[7:0] ^ q.s3[7:0])); // [R17]
        // Millisecond tick
        n.tick = (q.div == DIV_LAST);
        n.div = n.tick ? 16'h0000 : 16'(q.div + 16'h0001);
        // Command lines fire once per low period, after deb+1 ticks low
        for (int i = 0; i < NCMD; i++) begin
            if (q.s2[LN_CMD0+i] == q.s3[LN_CMD0+i]) begin
                if (q.s3[LN_CMD0+i]) begin
                    n.cnt[i] = 8'h00; // [R01]
                    n.fired[i] = 1'b0;
                end else if (!q.fired[i]) begin
                    if (q.cnt[i] > q.deb) begin
                        ev[i] = 1'b1; // [R17] [R02]
                        n.fired[i] = 1'b1;
                    end else if (q.tick) begin
                        n.cnt[i] = 8'(q.cnt[i] + 8'h01);
                    end
                end
            end
        end
        // Move sequencer; home beats latch beats step, events while moving drop
        n.start = 1'b0;
        case (q.st)
            ADPP_IDLE: begin
                if (ev != '0) begin
                    if (ev[EV_HOME]) begin
                        n.tgt = POS_FIRST; // [R16]
                    end else if (ev[EV_LATCH]) begin
                        n.tgt = dec_tgt; // [R13]
                    end else begin
                        n.tgt = step_tgt; // [R15] [R05]
                    end
                    if (!ev[EV_HOME] && ev[EV_LATCH] && !dec_ok) begin
                        n.err = 1'b1; // [R18]
                        st_set[ST_ERR] = 1'b1;
                    end else begin
                        n.cw = (n.tgt >= q.cur);
                        n.start = 1'b1;
                        n.st = ADPP_ARM;
                        st_set[ST_CMD] = 1'b1;
                    end
                end
            end
            ADPP_ARM: begin
                if (mot_busy_i) begin
                    n.st = ADPP_RUN;
                end
            end
            ADPP_RUN: begin
                if (!mot_busy_i) begin
                    n.st = ADPP_IDLE;
                    if (mot_stuck_i) begin
                        n.err = 1'b1;
                        n.code = 8'h00; // [R04]
                        st_set[ST_ERR] = 1'b1;
                    end else begin
                        n.err = 1'b0;
                        n.cur = q.tgt;
                        n.code = adpp_encode(7'(q.tgt + q.ofs - POS_FIRST), PARALLEL); // [R14]
                        st_set[ST_DONE] = 1'b1;
                    end
                end
            end
            default: begin
                n.st = ADPP_IDLE;
            end
        endcase
        // Bus: ack one cycle after the request, write lands on the ack edge
        n.ack = hit && !q.ack;
        if (hit && !q.ack) begin
            case (wb_adr_i)
                ADR_CTRL: n.rdat = {8'h00, q.deb, 1'b0, q.ofs, 1'b0, q.npos};
                ADR_STAT: n.rdat = {29'h0, q.stat};
                ADR_MASK: n.rdat = {29'h0, q.mask};
                ADR_POS: n.rdat = {22'h0, q.st != ADPP_IDLE, q.err, 1'b0, q.cur};
                default: n.rdat = 32'h0000_0000;
            endcase
        end
        if (wr && wb_adr_i == ADR_CTRL) begin
            if (wb_sel_i[0]) begin
                n.npos = adpp_clamp(wb_dat_i[6:0], PARALLEL ? PAR_MAX : BCD_MAX); // [R12]
            end
            if (wb_sel_i[1] && !PARALLEL) begin
                n.ofs = adpp_clamp(wb_dat_i[14:8], BCD_MAX); // [R11]
            end
            if (wb_sel_i[2]) begin
                n.deb = wb_dat_i[23:16];
            end
        end
        if (wr && wb_adr_i == ADR_MASK && wb_sel_i[0]) begin
            n.mask = wb_dat_i[ST_W-1:0];
        end
        // Write one clears; a same-cycle event wins over the clear
        n.stat = q.stat;
        if (wr && wb_adr_i == ADR_STAT && wb_sel_i[0]) begin
            n.stat = q.stat & ~wb_dat_i[ST_W-1:0];
        end
        n.stat = n.stat | st_set;
    end

    // Single state register, frozen while the enable is low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= RST;
        end else if (ce_i) begin
            q <= n;
        end
    end

    // Status pins are inverted register bits; motor, bus and irq outputs are not inverted
    assign pos_n_o = ~q.code; // [R03]
    assign run_n_o = (q.st == ADPP_IDLE);
    assign dir_n_o = ~q.cw;
    assign err_n_o = ~q.err;
    assign mot_start_o = q.start;
    assign mot_target_o = q.tgt;
    assign mot_cw_o = q.cw;
    assign wb_dat_o = q.rdat;
    assign wb_ack_o = q.ack;
    assign irq_o = |(q.stat & q.mask);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_run_end;
        q.st == ADPP_RUN && !mot_busy_i && ce_i;
    endsequence
    sequence s_stuck_end;
        s_run_end ##0 mot_stuck_i;
    endsequence
    sequence s_idle_cmd;
        q.st == ADPP_IDLE && ce_i;
    endsequence

    a_stuck_zero: assert property (s_stuck_end |=> pos_n_o == 8'hFF && !err_n_o) // [R04]
        else $error("stuck stop did not report zero");
    a_pos_only_done: assert property ($changed(pos_n_o) |-> $past(q.st) == ADPP_RUN && !$past(mot_busy_i) && $past(ce_i)) // [R14]
        else $error("position output changed outside move end");
    a_bad_latch: assert property (s_idle_cmd ##0 (ev[EV_LATCH] && !ev[EV_HOME] && !dec_ok)
        |=> !err_n_o && !mot_start_o && run_n_o) // [R18]
        else $error("invalid latch not rejected");
    a_step_one: assert property (s_idle_cmd ##0 (ev == 3'b001)
        |=> mot_start_o && mot_target_o == $past(step_tgt) ##1 !mot_start_o) // [R15]
        else $error("step did not advance one");
    a_home_first: assert property (s_idle_cmd ##0 ev[EV_HOME] |=> mot_start_o && mot_target_o == POS_FIRST) // [R16]
        else $error("home did not target first position");
    a_latch_move: assert property (s_idle_cmd ##0 (ev == 3'b100 && dec_ok)
        |=> mot_start_o && mot_target_o == $past(dec_tgt) && !run_n_o) // [R13]
        else $error("latch did not move to decoded position");
    a_high_no_event: assert property (q.s3[LN_CMD0+:NCMD] == 3'b111 |-> ev == 3'b000) // [R01]
        else $error("event from idle high line");
    a_stable_count: assert property (ev[EV_STEP] |-> q.cnt[EV_STEP] > q.deb && !q.s2[LN_CMD0] && !q.s3[LN_CMD0]) // [R17]
        else $error("step accepted before stable count");
    a_par_clamp: assert property (PARALLEL |-> q.npos <= PAR_MAX && q.ofs == PAR_OFFSET) // [R11] [R12]
        else $error("parallel count or offset out of range");
    a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule

// File: testbench/adpp_motor_model.sv
// Purpose: Behavioural motor mechanics behind the actuator port.
// Assumes: Same clock as the port; start is a one-cycle pulse.
// Notes: Busy length is short or long so both fast and slow moves are seen.
module adpp_motor_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Commands from the port and the bench
    input wire logic start_i,
    input wire logic slow_i,
    input wire logic stuck_cmd_i,
    // Answers to the port
    output logic busy_o,
    output logic stuck_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt;
    // Busy runs a fixed count after each start; a start mid-move restarts it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 6'h00;
        end else if (start_i) begin
            cnt <= slow_i ? 6'h28 : 6'h03;
        end else if (cnt != 6'h00) begin
            cnt <= cnt - 6'h01;
        end
    end
    assign busy_o = (cnt != 6'h00);
    // Stuck is a level so it is valid whenever the port samples it
    assign stuck_o = stuck_cmd_i;
endmodule

// File: testbench/tb_top.sv
// Purpose: Self-checking bench of the actuator digital position port.
// Assumes: BCD build plus a parallel build, 20-cycle ms tick, BCD accept count set to one ms.
// Notes: Register access is classic Wishbone; each build has its own motor model.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import adpp_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat_w = 32'h0, rd;
    logic [7:0] pos_n_i = 8'hFF;
    logic [2:0] cmd_n = 3'h7;
    logic stuck_cmd = 1'b0, slow = 1'b0, saw_run;
    wire logic [31:0] wb_dat_o;
    wire logic [7:0] pos_n_o;
    wire logic [6:0] tgt;
    wire logic wb_ack_o, irq_o, run_n_o, dir_n_o, err_n_o, start, cw, busy, stuck;
    int bad_count = 0, n_tests = 0, cycles = 0;
    adpp_port #(.MS_CYCLES(20)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
        .step_n_i(cmd_n[0]), .home_n_i(cmd_n[1]), .latch_n_i(cmd_n[2]), .pos_n_i(pos_n_i),
        .pos_n_o(pos_n_o), .run_n_o(run_n_o), .dir_n_o(dir_n_o), .err_n_o(err_n_o),
        .mot_start_o(start), .mot_target_o(tgt), .mot_cw_o(cw), .mot_busy_i(busy),
        .mot_stuck_i(stuck));
    adpp_motor_model i_mot (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .slow_i(slow),
        .stuck_cmd_i(stuck_cmd), .busy_o(busy), .stuck_o(stuck));
    // Parallel build on the same pins, reset defaults only, with its own mechanics
    wire logic [7:0] pos2_n;
    wire logic [6:0] tgt2;
    wire logic err2_n, start2, busy2, stuck2;
    adpp_port #(.PARALLEL(1'b1), .MS_CYCLES(20)) i_dut_par (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(1'b0), .wb_stb_i(1'b0), .wb_we_i(1'b0), .wb_adr_i(4'h0), .wb_sel_i(4'h0),
        .wb_dat_i(32'h0), .wb_dat_o(), .wb_ack_o(), .irq_o(),
        .step_n_i(cmd_n[0]), .home_n_i(cmd_n[1]), .latch_n_i(cmd_n[2]), .pos_n_i(pos_n_i),
        .pos_n_o(pos2_n), .run_n_o(), .dir_n_o(), .err_n_o(err2_n),
        .mot_start_o(start2), .mot_target_o(tgt2), .mot_cw_o(), .mot_busy_i(busy2),
        .mot_stuck_i(stuck2));
    adpp_motor_model i_mot_par (.clk_i(clk_i), .rst_i(rst_i), .start_i(start2), .slow_i(1'b0),
        .stuck_cmd_i(stuck_cmd), .busy_o(busy2), .stuck_o(stuck2));
    // 20 MHz clock and a cycle ceiling against hangs
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            bad_count++;
            stop_test();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One Wishbone cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        if (n >= 50) begin
            bad_count++;
            stop_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Pulse one command line low for len cycles, then let the move settle
    task automatic pulse(input int line, input int len);
        saw_run = 1'b0;
        @(posedge clk_i);
        cmd_n[line] <= 1'b0;
        repeat (len) begin
            @(posedge clk_i);
            if (run_n_o === 1'b0) saw_run = 1'b1;
        end
        cmd_n[line] <= 1'b1;
        // A late accepted glitch would only run after release, so keep watching
        repeat (60) begin
            @(posedge clk_i);
            if (run_n_o === 1'b0) saw_run = 1'b1;
        end
    endtask
    task automatic t_reset();
        check("pos", {24'h0, pos_n_o}, 32'h000000FF);
        check("err", {31'h0, err_n_o}, 32'h00000001);
        wb(1'b0, ADR_CTRL, 32'h0);
        check("ctrl", rd, 32'h0005010A);
        wb(1'b0, 4'h2, 32'h0);
        check("unmapped", rd, 32'h00000000);
        // One ms accept time: a few-cycle glitch can never span two ticks
        wb(1'b1, ADR_CTRL, 32'h00010160);
        wb(1'b1, ADR_MASK, 32'h00000001);
    endtask
    // Short glitch is rejected, then a held step advances one place
    task automatic t_step();
        pulse(0, 5);
        check("glitch", {31'h0, saw_run}, 32'h00000000);
        pulse(0, 640);
        check("ran", {31'h0, saw_run}, 32'h00000001);
        check("pos", {24'h0, pos_n_o}, 32'h000000FD);
        check("dir", {31'h0, dir_n_o}, 32'h00000000);
        check("target", {25'h0, tgt}, 32'h00000002);
        check("cw", {31'h0, cw}, 32'h00000001);
        check("irq", {31'h0, irq_o}, 32'h00000001);
        wb(1'b0, ADR_STAT, 32'h0);
        check("stat", rd, 32'h00000005);
        wb(1'b1, ADR_STAT, 32'h00000007);
        // The clear lands on the ack edge, so look one edge later
        @(posedge clk_i);
        check("irq clr", {31'h0, irq_o}, 32'h00000000);
    endtask
    // Latch a decimal code with a slow motor, then a bad digit
    task automatic t_latch();
        slow <= 1'b1;
        pos_n_i <= 8'hDC;
        pulse(2, 640);
        check("latch", {24'h0, pos_n_o}, 32'h000000DC);
        slow <= 1'b0;
        pos_n_i <= 8'hF5;
        pulse(2, 640);
        check("bad code", {31'h0, saw_run}, 32'h00000000);
        check("err", {31'h0, err_n_o}, 32'h00000000);
        check("kept", {24'h0, pos_n_o}, 32'h000000DC);
    endtask
    // Home from high place runs anticlockwise; stuck step reports zero
    task automatic t_home_stuck();
        pulse(1, 640);
        check("home", {24'h0, pos_n_o}, 32'h000000FE);
        check("dir", {31'h0, dir_n_o}, 32'h00000001);
        check("err", {31'h0, err_n_o}, 32'h00000001);
        stuck_cmd <= 1'b1;
        pulse(0, 640);
        check("stuck", {24'h0, pos_n_o}, 32'h000000FF);
        check("err", {31'h0, err_n_o}, 32'h00000000);
        wb(1'b0, ADR_POS, 32'h0);
        check("pos reg", rd, 32'h00000101);
    endtask
    // Parallel build: one low line picks its place, two low lines are refused
    task automatic t_parallel();
        stuck_cmd <= 1'b0;
        pos_n_i <= 8'hEF;
        pulse(2, 640);
        check("par pos", {24'h0, pos2_n}, 32'h000000EF);
        check("par target", {25'h0, tgt2}, 32'h00000005);
        check("par err", {31'h0, err2_n}, 32'h00000001);
        pos_n_i <= 8'hFC;
        pulse(2, 640);
        check("par two lines", {31'h0, err2_n}, 32'h00000000);
        check("par kept", {24'h0, pos2_n}, 32'h000000EF);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_reset();
        t_step();
        t_latch();
        t_home_stuck();
        t_parallel();
        stop_test();
    end
endmodule
